// File: bench/cdsr_chk.sv
// Port checker for the clock detect status register slice
module cdsr_chk
  import cdsr_pkg::*;
#(
  parameter logic [7:0] DIE_ID_VALUE = 8'h5a  // Arbitrary identity value
)(
  input wire logic       sys_clk,       // Control clock
  input wire logic       reset,         // Synchronous reset
  input wire cdsr_req_s  regReq,        // Register access
  input wire logic [7:0] regRdata,      // Read data
  input wire cdsr_det_s  detIn,         // Detector levels
  input wire logic       clockErrorIn,  // Clock error in
  input wire logic       clockError,    // Clock error out
  input wire cdsr_pins_s pinSrc,        // Pin sources
  input wire cdsr_pins_s pinOut         // Pin levels
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [7:0] pol;
  always_ff @(posedge sys_clk) begin
    if (reset) pol <= 8'h00;
    else if (regReq.write && regReq.addr == OFS_POLARITY) pol <= regReq.wdata & POL_WMASK;
  end
  sequence s_rd(logic [7:0] a);
    regReq.read && regReq.addr == a;
  endsequence
  property p_pin2; !$past(reset) |-> pinOut.generalPinTwo == $past(pinSrc.generalPinTwo ^ pol[5]); endproperty
  property p_mute; !$past(reset) |-> pinOut.muteSource == $past(pinSrc.muteSource ^ pol[4]); endproperty
  property p_pin0; !$past(reset) |-> pinOut.generalPinZero == $past(pinSrc.generalPinZero ^ pol[3]); endproperty
  property p_pol; s_rd(OFS_POLARITY) |=> regRdata == $past(pol); endproperty
  property p_id; s_rd(OFS_DIE_ID) |=> regRdata == DIE_ID_VALUE; endproperty
  property p_rate;
    s_rd(OFS_RATE) |=> regRdata[6:0] == $past({detIn.detectedSampleRate, detIn.detectedMasterRatio});
  endproperty
  property p_bck;
    s_rd(OFS_BCK_HIGH) ##2 s_rd(OFS_BCK_LOW) |=> regRdata == $past(detIn.detectedBitclkRatio[7:0]);
  endproperty
  property p_bckmsb; s_rd(OFS_BCK_HIGH) |=> regRdata[0] == $past(detIn.detectedBitclkRatio[8]); endproperty
  property p_err; !$past(reset) |-> clockError == $past(clockErrorIn); endproperty
  property p_stat; s_rd(OFS_CLK_STATE) |=> regRdata[6:0] == $past(detIn[6:0]); endproperty
  property p_hold; !regReq.read |=> $stable(regRdata); endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 polarity");
  a_mute: assert property (p_mute) else $error("mute polarity");
  a_pin0: assert property (p_pin0) else $error("pin 0 polarity");
  a_pol: assert property (p_pol) else $error("polarity readback");
  a_id: assert property (p_id) else $error("identity readback");
  a_rate: assert property (p_rate) else $error("rate readback");
  a_bck: assert property (p_bck) else $error("bit clock count readback");
  a_bckmsb: assert property (p_bckmsb) else $error("bit clock count top bit");
  a_err: assert property (p_err) else $error("clock error not registered");
  a_stat: assert property (p_stat) else $error("status readback");
  a_hold: assert property (p_hold) else $error("read data not held");
endmodule

bind clock_detect_status_regs cdsr_chk #(.DIE_ID_VALUE(DIE_ID_VALUE)) u_chk (.sys_clk(sys_clk), .reset(reset),
  .regReq(regReq), .regRdata(regRdata), .detIn(detIn), .clockErrorIn(clockErrorIn), .clockError(clockError),
  .pinSrc(pinSrc), .pinOut(pinOut));

// File: bench/cdsr_host.sv
// Host model issuing register accesses on the control port
module cdsr_host
  import cdsr_pkg::*;
(
  input  wire logic       sys_clk,   // Control clock
  output cdsr_req_s       regReq,    // Request to the register slice
  input  wire logic [7:0] regRdata   // Registered read data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial regReq = '0;
  // Idle lines show inverted values, not the last request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk) #1 regReq <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk) #1 regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge sys_clk) #1 regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk) #1 regReq <= '{1'b0, 1'b0, ~a, 8'hff};
    q = regRdata;
  endtask
endmodule

// File: bench/clock_detect_status_regs_tb.sv
// Testbench for the clock detect status register slice
module clock_detect_status_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cdsr_pkg::*;
  localparam logic [7:0] ID = 8'h3c;  // Arbitrary identity value
  logic       sys_clk = 1'b0;
  logic       reset = 1'b1;
  logic       clockErrorIn = 1'b0;
  logic       clockError;
  logic [7:0] regRdata;
  logic [2:0] m;
  cdsr_req_s  regReq;
  cdsr_det_s  detIn = '0;
  cdsr_pins_s pinSrc = 3'b101;
  cdsr_pins_s pinOut;
  int         err_count = 0;
  int         n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  cdsr_host u_host (.sys_clk(sys_clk), .regReq(regReq), .regRdata(regRdata));
  clock_detect_status_regs #(.DIE_ID_VALUE(ID)) u_dut (.sys_clk(sys_clk), .reset(reset), .regReq(regReq),
    .regRdata(regRdata), .detIn(detIn), .clockErrorIn(clockErrorIn), .clockError(clockError),
    .pinSrc(pinSrc), .pinOut(pinOut));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.rd(a, v);
    chk($sformatf("register %h", a), e, v);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    #1 reset = 1'b0;
    rc(OFS_POLARITY, RST_POLARITY);
    rc(OFS_RATE, 8'h00);
    rc(OFS_BCK_HIGH, 8'h00);
    rc(OFS_DIE_ID, ID);
    u_host.wr(OFS_DIE_ID, 8'hff);
    rc(OFS_DIE_ID, ID);
    for (int i = 0; i < 4; i++) begin
      m = (i < 3) ? 3'(1 << i) : 3'b000;
      pinSrc = 3'(i + 5);
      u_host.wr(OFS_POLARITY, {2'b11, m, 3'b111});
      rc(OFS_POLARITY, {2'b00, m, 3'b000});
      chk("pins", {5'h00, pinSrc ^ m}, {5'h00, pinOut});
    end
    u_host.wr(OFS_BCK_LOW, 8'hff);
    u_host.wr(OFS_CLK_STATE, 8'h7f);
    u_host.wr(OFS_RATE, 8'h7f);
    u_host.wr(OFS_BCK_HIGH, 8'h01);
    for (int k = 0; k < 7; k++) begin
      detIn = {3'(k), k[0] ? MRATIO_32FS : MRATIO_ERROR, k[0], 8'(8'ha5 + k), 7'(1 << k)};
      rc(OFS_RATE, {1'b0, 3'(k), k[0] ? MRATIO_32FS : MRATIO_ERROR});
      rc(OFS_BCK_HIGH, {7'h00, k[0]});
      rc(OFS_BCK_LOW, 8'(8'ha5 + k));
      rc(OFS_CLK_STATE, {1'b0, 7'(1 << k)});
    end
    rc(8'h60, 8'h00);
    chk("clockError", 8'h00, {7'h00, clockError});
    clockErrorIn = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("clockError", 8'h01, {7'h00, clockError});
    report_and_stop;
  end
endmodule

// File: include/cdsr_pkg.sv
// Package of constants and carriers for the clock detect status register slice
package cdsr_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_POLARITY  = 8'h57;
  localparam logic [7:0] OFS_DIE_ID    = 8'h58;
  localparam logic [7:0] OFS_RATE      = 8'h5b;
  localparam logic [7:0] OFS_BCK_HIGH  = 8'h5c;
  localparam logic [7:0] OFS_BCK_LOW   = 8'h5d;
  localparam logic [7:0] OFS_CLK_STATE = 8'h5e;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int POS_PIN2_POL  = 5;
  localparam int POS_MUTE_POL  = 4;
  localparam int POS_PIN0_POL  = 3;
  localparam int POS_MCLK_MISS = 6;
  localparam int POS_PLL_UNLK  = 5;
  localparam int POS_SER_MISS  = 4;
  localparam int POS_RATIO_ERR = 3;
  localparam int POS_MCLK_INV  = 2;
  localparam int POS_BCK_INV   = 1;
  localparam int POS_FS_INV    = 0;
  localparam logic [7:0] RST_POLARITY = 8'h00;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [7:0] POL_WMASK    = 8'h38;
  localparam logic [3:0] MRATIO_ERROR = 4'h0;
  localparam logic [3:0] MRATIO_32FS  = 4'h1;
  localparam logic [7:0] RST_RDATA    = 8'h00;
  localparam logic       RST_FLAG     = 1'b0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic       write;     // Write strobe
    logic       read;      // Read strobe
    logic [7:0] addr;      // Register offset
    logic [7:0] wdata;     // Write data
  } cdsr_req_s;

  typedef struct packed {
    logic [2:0] detectedSampleRate;   // Measured rate code
    logic [3:0] detectedMasterRatio;  // Measured master ratio code
    logic [8:0] detectedBitclkRatio;  // Bit clocks per frame
    logic       masterClockMissing;
    logic       pllUnlocked;
    logic       serialClocksMissing;
    logic       ratioComboError;
    logic       masterClockInvalid;
    logic       bitclkInvalid;
    logic       sampleRateInvalid;
  } cdsr_det_s;

  typedef struct packed {
    logic generalPinTwo;  // Selected source for pin 2
    logic muteSource;     // Selected mute source
    logic generalPinZero; // Selected source for pin 0
  } cdsr_pins_s;

endpackage

// File: verilog/cdsr_pin_polarity.sv
// Output polarity stage for the two general pins and the mute pin
module cdsr_pin_polarity
  import cdsr_pkg::*;
(
  input  wire logic       sys_clk,  // Control clock
  input  wire logic       reset,    // Synchronous reset, active high
  input  wire logic [7:0] polReg,   // Polarity control register
  input  wire cdsr_pins_s srcIn,    // Selected sources
  output cdsr_pins_s      pinsOut   // Driven pin levels
);

  wire cdsr_pins_s pinsNext;

  // ****************************************
  // Inversion
  // ****************************************
  assign pinsNext.generalPinTwo  = srcIn.generalPinTwo ^ polReg[POS_PIN2_POL];
  assign pinsNext.muteSource     = srcIn.muteSource ^ polReg[POS_MUTE_POL];
  assign pinsNext.generalPinZero = srcIn.generalPinZero ^ polReg[POS_PIN0_POL];

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pinsOut <= '0;
    end else begin
      pinsOut <= pinsNext;
    end
  end

endmodule

// File: verilog/clock_detect_status_regs.sv
// Register slice: output polarity, die identifier and clock detector readback
module clock_detect_status_regs
  import cdsr_pkg::*;
#(
  parameter logic [7:0] DIE_ID_VALUE = 8'h5a  // Arbitrary identity value
)(
  input  wire logic       sys_clk,       // Control clock, 100 MHz
  input  wire logic       reset,         // Synchronous reset, active high
  input  wire cdsr_req_s  regReq,        // Register access from control port
  output logic [7:0]      regRdata,      // Read data, registered
  input  wire cdsr_det_s  detIn,         // Clock detector measurements
  input  wire logic       clockErrorIn,  // Detector combined clock error
  output logic            clockError,    // Clock error, registered
  input  wire cdsr_pins_s pinSrc,        // Selected pin sources
  output cdsr_pins_s      pinOut         // Pin levels after polarity
);

  // ****************************************
  // Request fields
  // ****************************************
  wire       writeReq = regReq.write;
  wire       readReq  = regReq.read;
  wire [7:0] reqAddr  = regReq.addr;
  wire [7:0] reqWdata = regReq.wdata;

  // ****************************************
  // Address decode
  // ****************************************
  wire selPol;
  wire selDieId;
  wire selRate;
  wire selBckHi;
  wire selBckLo;
  wire selState;

  assign selPol   = reqAddr == OFS_POLARITY;
  assign selDieId = reqAddr == OFS_DIE_ID;
  assign selRate  = reqAddr == OFS_RATE;
  assign selBckHi = reqAddr == OFS_BCK_HIGH;
  assign selBckLo = reqAddr == OFS_BCK_LOW;
  assign selState = reqAddr == OFS_CLK_STATE;

  // ****************************************
  // Write decode
  // ****************************************
  wire hitPol;
  wire hitRate;
  wire hitBckHi;
  wire hitState;

  // No store behind the identifier or the low count byte
  assign hitPol   = writeReq && selPol;
  assign hitRate  = writeReq && selRate;
  assign hitBckHi = writeReq && selBckHi;
  assign hitState = writeReq && selState;

  // ****************************************
  // Output polarity register
  // ****************************************
  logic [7:0] polarity_reg;
  logic [7:0] polarity_next;

  // Only defined polarity bits store; reserved bits stay zero
  assign polarity_next = hitPol ? (reqWdata & POL_WMASK) : polarity_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      polarity_reg <= RST_POLARITY;
    end else begin
      polarity_reg <= polarity_next;
    end
  end

  // ****************************************
  // Reserved bit of the rate register
  // ****************************************
  logic rateRsv_reg;
  logic rateRsv_next;

  // Read-only rate fields drop the written bits
  assign rateRsv_next = hitRate ? reqWdata[7] : rateRsv_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rateRsv_reg <= RST_FLAG;
    end else begin
      rateRsv_reg <= rateRsv_next;
    end
  end

  // ****************************************
  // Reserved bits of the count high byte
  // ****************************************
  logic [6:0] bckHighRsv_reg;
  logic [6:0] bckHighRsv_next;

  assign bckHighRsv_next = hitBckHi ? reqWdata[7:1] : bckHighRsv_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bckHighRsv_reg <= RST_RESERVED[6:0];
    end else begin
      bckHighRsv_reg <= bckHighRsv_next;
    end
  end

  // ****************************************
  // Reserved bit of the status register
  // ****************************************
  logic stateRsv_reg;
  logic stateRsv_next;

  assign stateRsv_next = hitState ? reqWdata[7] : stateRsv_reg;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      stateRsv_reg <= RST_FLAG;
    end else begin
      stateRsv_reg <= stateRsv_next;
    end
  end

  // ****************************************
  // Detector fields, read live
  // ****************************************
  wire [2:0] sampleRate  = detIn.detectedSampleRate;
  wire [3:0] masterRatio = detIn.detectedMasterRatio;
  wire [8:0] bitclkRatio = detIn.detectedBitclkRatio;
  wire       mclkMissing = detIn.masterClockMissing;
  wire       pllUnlocked = detIn.pllUnlocked;
  wire       serialMiss  = detIn.serialClocksMissing;
  wire       ratioError  = detIn.ratioComboError;
  wire       mclkInvalid = detIn.masterClockInvalid;
  wire       bckInvalid  = detIn.bitclkInvalid;
  wire       rateInvalid = detIn.sampleRateInvalid;

  // ****************************************
  // Readback words
  // ****************************************
  wire [7:0] rateWord = {rateRsv_reg,  // Reserved, stored
                         sampleRate,
                         masterRatio};
  wire [7:0] bckHigh  = {bckHighRsv_reg, bitclkRatio[8]};
  wire [7:0] bckLow   = bitclkRatio[7:0];
  wire [7:0] stateWord;

  assign stateWord[7]             = stateRsv_reg;
  assign stateWord[POS_MCLK_MISS] = mclkMissing;
  assign stateWord[POS_PLL_UNLK]  = pllUnlocked;
  assign stateWord[POS_SER_MISS]  = serialMiss;
  assign stateWord[POS_RATIO_ERR] = ratioError;
  assign stateWord[POS_MCLK_INV]  = mclkInvalid;
  assign stateWord[POS_BCK_INV]   = bckInvalid;
  assign stateWord[POS_FS_INV]    = rateInvalid;

  // ****************************************
  // Read select
  // ****************************************
  wire [7:0] rdPol   = selPol   ? polarity_reg : RST_RDATA;
  wire [7:0] rdDieId = selDieId ? DIE_ID_VALUE : RST_RDATA;
  wire [7:0] rdRate  = selRate  ? rateWord     : RST_RDATA;
  wire [7:0] rdBckHi = selBckHi ? bckHigh      : RST_RDATA;
  wire [7:0] rdBckLo = selBckLo ? bckLow       : RST_RDATA;
  wire [7:0] rdState = selState ? stateWord    : RST_RDATA;

  // Unmapped offsets fall through as zero
  wire [7:0] rdataSel = rdPol
                      | rdDieId
                      | rdRate
                      | rdBckHi
                      | rdBckLo
                      | rdState;

  // Read data holds between reads
  wire [7:0] regRdata_next = readReq ? rdataSel : regRdata;

  // ****************************************
  // Read data register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      regRdata <= RST_RDATA;
    end else begin
      regRdata <= regRdata_next;
    end
  end

  // ****************************************
  // Clock error
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      clockError <= RST_FLAG;
    end else begin
      clockError <= clockErrorIn;
    end
  end

  // ****************************************
  // Pin polarity
  // ****************************************
  cdsr_pin_polarity uPolarity (
    .sys_clk (sys_clk),
    .reset   (reset),
    .polReg  (polarity_reg),
    .srcIn   (pinSrc),
    .pinsOut (pinOut)
  );

endmodule
